/* File: core/fec_pkg.sv */
package fec_pkg;

    // ------------------------------------------------------------------
    // Command words and unlock addresses
    // ------------------------------------------------------------------
    localparam logic [7:0]  CMD_UNLOCK1      = 8'haa;
    localparam logic [7:0]  CMD_UNLOCK2      = 8'h55;
    localparam logic [7:0]  CMD_ERASE_SETUP  = 8'h80;
    localparam logic [7:0]  CMD_CHIP_ERASE   = 8'h10;
    localparam logic [7:0]  CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0]  CMD_RESUME       = 8'h30;
    localparam logic [7:0]  CMD_SUSPEND      = 8'hb0;
    localparam logic [7:0]  CMD_PROGRAM      = 8'ha0;
    localparam logic [7:0]  CMD_BYPASS       = 8'h20;
    localparam logic [7:0]  CMD_BYPASS_EXIT1 = 8'h90;
    localparam logic [7:0]  CMD_BYPASS_EXIT2 = 8'h00;
    localparam logic [7:0]  CMD_RESET        = 8'hf0;
    localparam logic [18:0] ADDR_BYTE_U1     = 19'h00aaa;
    localparam logic [18:0] ADDR_BYTE_U2     = 19'h00555;
    localparam logic [18:0] ADDR_WORD_U1     = 19'h00555;
    localparam logic [18:0] ADDR_WORD_U2     = 19'h002aa;
    localparam logic [18:0] ADDR_ZERO        = 19'h00000;

    // ------------------------------------------------------------------
    // Host operations
    // ------------------------------------------------------------------
    localparam logic [2:0] OP_CHIP_ERASE   = 3'h0;
    localparam logic [2:0] OP_SECTOR_ERASE = 3'h1;
    localparam logic [2:0] OP_SECTOR_ADD   = 3'h2;
    localparam logic [2:0] OP_SUSPEND      = 3'h3;
    localparam logic [2:0] OP_RESUME       = 3'h4;
    localparam logic [2:0] OP_PROGRAM      = 3'h5;
    localparam logic [2:0] OP_BYPASS_ENTER = 3'h6;
    localparam logic [2:0] OP_BYPASS_EXIT  = 3'h7;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ           = 250;
    localparam int WIN_US            = 50;
    localparam int WIN_CYC           = WIN_US * CLK_MHZ;
    localparam int SUSPEND_US        = 20;
    localparam int SUSPEND_CYC       = SUSPEND_US * CLK_MHZ;
    localparam int STROBE_LOW_NS     = 40;
    localparam int STROBE_LOW_CYC    = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_PULSE_NS    = 500;
    localparam int RESET_PULSE_CYC   = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        FEC_IDLE  = 5'b00001,
        FEC_SETUP = 5'b00010,
        FEC_LOW   = 5'b00100,
        FEC_HIGH  = 5'b01000,
        FEC_RST   = 5'b10000
    } fec_state_t;

endpackage : fec_pkg

/* File: core/fec_host.sv */
`timescale 1ns/1ns
// Summary of operation
// - Chip erase: unlock, unlock, 80, unlock, unlock, 10.
// - Sector erase: same five, then sector plus 30.
// - Reset pin aborts erase; caller reissues sequence.
// - Host tracks a 50us window; caller spaces extra sector writes.
// - Program: unlock, unlock, A0, address with data.
// - Bypass: unlock, unlock, 20; 90, 00 exit.
module fec_host #(
    parameter int WIN_CYC     = fec_pkg::WIN_CYC,
    parameter int SUSPEND_CYC = fec_pkg::SUSPEND_CYC
) (
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic        op_valid_in,
    input  wire logic [2:0]  op_code_in,
    input  wire logic [18:0] op_addr_in,
    input  wire logic [15:0] op_data_in,
    input  wire logic        byte_mode_in,
    input  wire logic        hw_reset_in,
    input  wire logic        lower_ready_busy_in,
    input  wire logic        upper_ready_busy_in,
    output logic             op_ready_out,
    output logic             op_done_out,
    output logic             busy_out,
    output logic             suspend_wait_out,
    output logic [18:0]      flash_addr_out,
    output logic [15:0]      flash_data_out,
    output logic             flash_data_oe_out,
    output logic             flash_write_strobe_n_out,
    output logic             flash_chip_select_n_out,
    output logic             flash_output_enable_n_out,
    output logic             flash_reset_n_out,
    output logic             width_select_pins_out
);
    localparam int CW = 16;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rb_meta;
    logic [1:0] rb_sync;
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rb_meta <= 2'h3;
            rb_sync <= 2'h3;
        end else begin
            rb_meta <= {upper_ready_busy_in, lower_ready_busy_in};
            rb_sync <= rb_meta;
        end
    end
    wire dev_busy = ~&rb_sync;

    // ------------------------------------------------------------------
    // Write list for the requested operation
    // ------------------------------------------------------------------
    logic [18:0] seq_addr [0:5];
    logic [7:0]  seq_cmd  [0:5];
    logic [2:0]  seq_len;
    logic [2:0]  seq_idx;
    logic [2:0]  cur_op;
    logic [18:0] u1;
    logic [18:0] u2;
    always_comb begin
        u1 = byte_mode_in ? fec_pkg::ADDR_BYTE_U1 : fec_pkg::ADDR_WORD_U1;
        u2 = byte_mode_in ? fec_pkg::ADDR_BYTE_U2 : fec_pkg::ADDR_WORD_U2;
    end

    fec_pkg::fec_state_t state;
    logic [CW-1:0]       cnt;
    logic [CW-1:0]       win_cnt;
    logic                win_open;
    logic [CW-1:0]       sus_cnt;
    logic                prog_last;
    logic [15:0]         op_data_hold;

    wire take = op_valid_in && op_ready_out;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state                     <= fec_pkg::FEC_IDLE;
            op_ready_out              <= 1'b0;
            op_done_out               <= 1'b0;
            seq_len                   <= 3'h0;
            seq_idx                   <= 3'h0;
            cur_op                    <= 3'h0;
            cnt                       <= '0;
            prog_last                 <= 1'b0;
            flash_addr_out            <= fec_pkg::ADDR_ZERO;
            flash_data_out            <= 16'h0000;
            flash_data_oe_out         <= 1'b0;
            flash_write_strobe_n_out  <= 1'b1;
            flash_chip_select_n_out   <= 1'b1;
            flash_output_enable_n_out <= 1'b1;
            flash_reset_n_out         <= 1'b1;
            width_select_pins_out     <= 1'b0;
            for (int i = 0; i < 6; i++) begin
                seq_addr[i] <= fec_pkg::ADDR_ZERO;
                seq_cmd[i]  <= 8'h00;
            end
        end else begin
            op_done_out           <= 1'b0;
            width_select_pins_out <= ~byte_mode_in;
            unique case (state)
                fec_pkg::FEC_IDLE: begin
                    op_ready_out <= 1'b1;
                    if (hw_reset_in) begin
                        // Hardware reset aborts any erase; the caller must reissue it.
                        op_ready_out      <= 1'b0;
                        flash_reset_n_out <= 1'b0;
                        cnt               <= '0;
                        state             <= fec_pkg::FEC_RST;
                    end else if (take) begin
                        op_ready_out <= 1'b0;
                        cur_op       <= op_code_in;
                        seq_idx      <= 3'h0;
                        prog_last    <= 1'b0;
                        seq_addr[0] <= u1;
                        seq_cmd[0]  <= fec_pkg::CMD_UNLOCK1;
                        seq_addr[1] <= u2;
                        seq_cmd[1]  <= fec_pkg::CMD_UNLOCK2;
                        seq_addr[3] <= u1;
                        seq_cmd[3]  <= fec_pkg::CMD_UNLOCK1;
                        seq_addr[4] <= u2;
                        seq_cmd[4]  <= fec_pkg::CMD_UNLOCK2;
                        seq_addr[2] <= u1;
                        unique case (op_code_in)
                            fec_pkg::OP_CHIP_ERASE: begin
                                seq_cmd[2]  <= fec_pkg::CMD_ERASE_SETUP;
                                seq_addr[5] <= u1;
                                seq_cmd[5]  <= fec_pkg::CMD_CHIP_ERASE;
                                seq_len     <= 3'h6;
                            end
                            fec_pkg::OP_SECTOR_ERASE: begin
                                seq_cmd[2]  <= fec_pkg::CMD_ERASE_SETUP;
                                seq_addr[5] <= {op_addr_in[18:12], 12'h000};
                                seq_cmd[5]  <= fec_pkg::CMD_SECTOR_ERASE;
                                seq_len     <= 3'h6;
                            end
                            fec_pkg::OP_SECTOR_ADD: begin
                                seq_addr[0] <= {op_addr_in[18:12], 12'h000};
                                seq_cmd[0]  <= fec_pkg::CMD_SECTOR_ERASE;
                                seq_len     <= 3'h1;
                            end
                            fec_pkg::OP_SUSPEND: begin
                                seq_addr[0] <= fec_pkg::ADDR_ZERO;
                                seq_cmd[0]  <= fec_pkg::CMD_SUSPEND;
                                seq_len     <= 3'h1;
                            end
                            fec_pkg::OP_RESUME: begin
                                seq_addr[0] <= fec_pkg::ADDR_ZERO;
                                seq_cmd[0]  <= fec_pkg::CMD_RESUME;
                                seq_len     <= 3'h1;
                            end
                            fec_pkg::OP_PROGRAM: begin
                                seq_cmd[2]  <= fec_pkg::CMD_PROGRAM;
                                seq_addr[3] <= op_addr_in;
                                seq_len     <= 3'h4;
                                prog_last   <= 1'b1;
                            end
                            fec_pkg::OP_BYPASS_ENTER: begin
                                seq_cmd[2] <= fec_pkg::CMD_BYPASS;
                                seq_len    <= 3'h3;
                            end
                            fec_pkg::OP_BYPASS_EXIT: begin
                                seq_addr[0] <= fec_pkg::ADDR_ZERO;
                                seq_cmd[0]  <= fec_pkg::CMD_BYPASS_EXIT1;
                                seq_addr[1] <= fec_pkg::ADDR_ZERO;
                                seq_cmd[1]  <= fec_pkg::CMD_BYPASS_EXIT2;
                                seq_len     <= 3'h2;
                            end
                        endcase
                        state <= fec_pkg::FEC_SETUP;
                    end
                end
                fec_pkg::FEC_SETUP: begin
                    // Address is set a cycle before select falls so it is stable at capture.
                    flash_addr_out    <= seq_addr[seq_idx];
                    flash_data_out    <= (prog_last && seq_idx == 3'h3) ? op_data_hold
                                                                         : {8'h00, seq_cmd[seq_idx]};
                    flash_data_oe_out <= 1'b1;
                    cnt               <= '0;
                    state             <= fec_pkg::FEC_LOW;
                end
                fec_pkg::FEC_LOW: begin
                    flash_chip_select_n_out  <= 1'b0;
                    flash_write_strobe_n_out <= 1'b0;
                    cnt                      <= cnt + 1'b1;
                    if (cnt == CW'(fec_pkg::STROBE_LOW_CYC)) begin
                        // Both rise together, so data is latched on that edge.
                        flash_chip_select_n_out  <= 1'b1;
                        flash_write_strobe_n_out <= 1'b1;
                        state                    <= fec_pkg::FEC_HIGH;
                    end
                end
                fec_pkg::FEC_HIGH: begin
                    flash_data_oe_out <= 1'b0;
                    if (seq_idx == seq_len - 3'h1) begin
                        op_done_out <= 1'b1;
                        state       <= fec_pkg::FEC_IDLE;
                    end else begin
                        seq_idx <= seq_idx + 3'h1;
                        state   <= fec_pkg::FEC_SETUP;
                    end
                end
                fec_pkg::FEC_RST: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == CW'(fec_pkg::RESET_PULSE_CYC)) begin
                        flash_reset_n_out <= 1'b1;
                        op_done_out       <= 1'b1;
                        state             <= fec_pkg::FEC_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            op_data_hold <= 16'h0000;
        end else if (take) begin
            op_data_hold <= op_data_in;
        end
    end

    // ------------------------------------------------------------------
    // Gathering window and suspend wait tracking
    // ------------------------------------------------------------------
    wire last_rise = state == fec_pkg::FEC_HIGH && seq_idx == seq_len - 3'h1;
    wire erase_cmd = cur_op == fec_pkg::OP_SECTOR_ERASE || cur_op == fec_pkg::OP_SECTOR_ADD;
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            win_cnt  <= '0;
            win_open <= 1'b0;
        end else if (last_rise && erase_cmd) begin
            win_cnt  <= CW'(WIN_CYC - 1);
            win_open <= 1'b1;
        end else if (hw_reset_in || (last_rise && cur_op == fec_pkg::OP_SUSPEND)) begin
            win_open <= 1'b0;
        end else if (win_open) begin
            win_cnt  <= win_cnt - 1'b1;
            win_open <= win_cnt != '0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sus_cnt <= '0;
        end else if (last_rise && cur_op == fec_pkg::OP_SUSPEND) begin
            sus_cnt <= CW'(SUSPEND_CYC);
        end else if (sus_cnt != '0) begin
            sus_cnt <= sus_cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            busy_out         <= 1'b0;
            suspend_wait_out <= 1'b0;
        end else begin
            busy_out         <= dev_busy;
            suspend_wait_out <= sus_cnt != '0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_strobe_pairs : assert property (@(posedge core_clk_in) disable iff (rst_in)
        $rose(flash_write_strobe_n_out) |-> $rose(flash_chip_select_n_out))
        else $error("Strobe and select did not rise together.");
    a_addr_stable : assert property (@(posedge core_clk_in) disable iff (rst_in)
        !flash_chip_select_n_out |-> $stable(flash_addr_out))
        else $error("Address moved during a write.");
    a_oe_off_write : assert property (@(posedge core_clk_in) disable iff (rst_in)
        !flash_write_strobe_n_out |-> flash_output_enable_n_out && flash_data_oe_out)
        else $error("Write cycle without driven data.");
    a_reset_pulse : assert property (@(posedge core_clk_in) disable iff (rst_in)
        $fell(flash_reset_n_out) |-> !flash_reset_n_out [*2])
        else $error("Reset pulse too short.");
    a_unlock_order : assert property (@(posedge core_clk_in) disable iff (rst_in)
        state == fec_pkg::FEC_LOW && seq_idx == 3'h0 && cur_op != fec_pkg::OP_SECTOR_ADD
        && cur_op != fec_pkg::OP_SUSPEND && cur_op != fec_pkg::OP_RESUME
        && cur_op != fec_pkg::OP_BYPASS_EXIT |-> flash_data_out == {8'h00, fec_pkg::CMD_UNLOCK1})
        else $error("First write of a sequence is not the unlock word.");
    a_setup_word : assert property (@(posedge core_clk_in) disable iff (rst_in)
        state == fec_pkg::FEC_LOW && seq_idx == 3'h2 && cur_op == fec_pkg::OP_PROGRAM
        |-> flash_data_out[7:0] == fec_pkg::CMD_PROGRAM)
        else $error("Third program write is not the program setup word.");
    a_window_reset : assert property (@(posedge core_clk_in) disable iff (rst_in)
        hw_reset_in && state == fec_pkg::FEC_IDLE |=> !win_open)
        else $error("Gathering window survived a hardware reset.");
endmodule : fec_host

/* File: verification/fec_flash_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------------
// One byte lane of the flash: command decoder and erase timing
// ------------------------------------------------------------------
module fec_flash_model #(
    parameter int ERASE_NS = 2000,
    parameter int WIN_NS   = 200
) (
    input  wire logic        strobe_n_in,
    input  wire logic        select_n_in,
    input  wire logic        reset_n_in,
    input  wire logic [18:0] addr_in,
    input  wire logic [15:0] data_in,
    output logic             ready_busy_out
);
    logic [18:0] log_a [0:63];
    logic [15:0] log_d [0:63];
    logic [18:0] lat_a;
    int          log_n    = 0;
    int          step     = 0;
    int          win_left = 0;
    int          run_left = 0;
    logic        chip     = 1'b0;
    logic        susp     = 1'b0;
    logic        autosel  = 1'b0;
    logic        erase_window_timer_bit = 1'b0;
    wire         wr_n     = strobe_n_in | select_n_in;

    always @(negedge wr_n) lat_a = addr_in;
    always @(posedge wr_n) begin : take_write
        logic [7:0] d;
        d = data_in[7:0];
        log_a[log_n % 64] = lat_a;
        log_d[log_n % 64] = data_in;
        log_n++;
        if (run_left > 0 && chip) begin
            // Chip erase runs to the end whatever is written.
            d = 8'h00;
        // While suspended, commands other than suspend and resume reach the decoder.
        end else if (run_left > 0 && !(susp && d != 8'h30 && d != 8'hb0)) begin
            if (d == 8'hb0) begin
                susp = 1'b1;
                win_left = 0;
            end else if (d == 8'h30 && win_left > 0) win_left = WIN_NS;
            else if (d == 8'h30) susp = 1'b0;
        end else if (d == 8'hf0) begin
            step = 0;
            autosel = 1'b0;
        end else begin
            case (step)
                0, 3: step = (d == 8'haa) ? step + 1 : 0;
                1, 4: step = (d == 8'h55) ? step + 1 : 0;
                2: begin
                    // Autoselect reads are not modelled; entering it leaves a suspend in place.
                    autosel = (d == 8'h90);
                    step = (d == 8'h80) ? 3 : 0;
                end
                default: begin
                    chip = (d == 8'h10);
                    if (d == 8'h10 || d == 8'h30) run_left = ERASE_NS;
                    win_left = (d == 8'h30) ? WIN_NS : 0;
                    step = 0;
                end
            endcase
        end
    end

    // A coarse 10 ns tick is plenty against strobes of ten cycles.
    always begin : run_timer
        #10;
        if (!reset_n_in) begin
            run_left = 0;
            win_left = 0;
            susp = 1'b0;
            step = 0;
        end else if (win_left > 0) win_left -= 10;
        else if (run_left > 0 && !susp) run_left -= 10;
        ready_busy_out = !(run_left > 0 && !susp);
        erase_window_timer_bit = run_left > 0 && win_left == 0;
    end
endmodule : fec_flash_model

/* File: verification/tb.sv */
`timescale 1ns/1ns
module tb;
    typedef struct {
        logic [2:0]  op;
        logic [18:0] a;
        logic [15:0] d;
        logic        bm;
    } fec_row_t;

    logic        core_clk_in  = 1'b0;
    logic        rst_in       = 1'b1;
    logic        op_valid_in  = 1'b0;
    logic [2:0]  op_code_in   = 3'h0;
    logic [18:0] op_addr_in   = 19'h00000;
    logic [15:0] op_data_in   = 16'h0000;
    logic        byte_mode_in = 1'b1;
    logic        hw_reset_in  = 1'b0;
    logic        rb_lo, rb_hi, rdy, done, busy, swait, oe, we_n, cs_n, oe_n, frst_n, wsel;
    logic [18:0] faddr;
    logic [15:0] fdata;
    logic [18:0] ex_a [0:7];
    logic [15:0] ex_d [0:7];
    logic        ex_c [0:7];
    logic        ex_f [0:7];
    fec_row_t    rows [0:7];
    int          n_ex, err_total, n_checks, base, k;

    always #2 core_clk_in = ~core_clk_in;

    fec_host #(.WIN_CYC(50), .SUSPEND_CYC(20)) dut_u (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .op_valid_in(op_valid_in),
        .op_code_in(op_code_in), .op_addr_in(op_addr_in), .op_data_in(op_data_in),
        .byte_mode_in(byte_mode_in), .hw_reset_in(hw_reset_in),
        .lower_ready_busy_in(rb_lo), .upper_ready_busy_in(rb_hi), .op_ready_out(rdy),
        .op_done_out(done), .busy_out(busy), .suspend_wait_out(swait),
        .flash_addr_out(faddr), .flash_data_out(fdata), .flash_data_oe_out(oe),
        .flash_write_strobe_n_out(we_n), .flash_chip_select_n_out(cs_n),
        .flash_output_enable_n_out(oe_n), .flash_reset_n_out(frst_n),
        .width_select_pins_out(wsel));
    fec_flash_model flash_lo (.strobe_n_in(we_n), .select_n_in(cs_n), .reset_n_in(frst_n),
        .addr_in(faddr), .data_in(fdata), .ready_busy_out(rb_lo));
    fec_flash_model flash_hi (.strobe_n_in(we_n), .select_n_in(cs_n), .reset_n_in(frst_n),
        .addr_in(faddr), .data_in(fdata), .ready_busy_out(rb_hi));

    // ------------------------------------------------------------------
    // Checking and driving tasks
    // ------------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic check_val(input string what, input logic [18:0] exp, input logic [18:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic put(input logic [18:0] a, input logic [15:0] d, input logic c, input logic f);
        ex_a[n_ex] = a;
        ex_d[n_ex] = d;
        ex_c[n_ex] = c;
        ex_f[n_ex] = f;
        n_ex++;
    endtask : put

    task automatic expect_seq(input fec_row_t r);
        logic [18:0] u1;
        logic [18:0] u2;
        u1 = r.bm ? fec_pkg::ADDR_BYTE_U1 : fec_pkg::ADDR_WORD_U1;
        u2 = r.bm ? fec_pkg::ADDR_BYTE_U2 : fec_pkg::ADDR_WORD_U2;
        n_ex = 0;
        if (r.op <= 3'h1 || r.op == 3'h5 || r.op == 3'h6) begin
            put(u1, 16'h00aa, 1'b1, 1'b0);
            put(u2, 16'h0055, 1'b1, 1'b0);
        end
        if (r.op <= 3'h1) begin
            put(u1, 16'h0080, 1'b1, 1'b0);
            put(u1, 16'h00aa, 1'b1, 1'b0);
            put(u2, 16'h0055, 1'b1, 1'b0);
        end
        case (r.op)
            fec_pkg::OP_CHIP_ERASE: put(u1, 16'h0010, 1'b1, 1'b0);
            fec_pkg::OP_SUSPEND: put(19'h00000, 16'h00b0, 1'b0, 1'b0);
            fec_pkg::OP_RESUME: put(19'h00000, 16'h0030, 1'b0, 1'b0);
            fec_pkg::OP_PROGRAM: begin
                put(u1, 16'h00a0, 1'b1, 1'b0);
                put(r.a, r.d, 1'b1, 1'b1);
            end
            fec_pkg::OP_BYPASS_ENTER: put(u1, 16'h0020, 1'b1, 1'b0);
            fec_pkg::OP_BYPASS_EXIT: begin
                put(19'h00000, 16'h0090, 1'b0, 1'b0);
                put(19'h00000, 16'h0000, 1'b0, 1'b0);
            end
            default: put({r.a[18:12], 12'h000}, 16'h0030, 1'b1, 1'b0);
        endcase
    endtask : expect_seq

    // Requests change only at the falling edge, where ready and done are settled.
    task automatic do_op(input fec_row_t r);
        logic [15:0] m;
        base = flash_lo.log_n;
        for (k = 0; rdy !== 1'b1 && k < 2000; k++) @(negedge core_clk_in);
        if (k >= 2000) begin
            err_total++;
            close_out();
        end
        op_valid_in = 1'b1;
        op_code_in = r.op;
        op_addr_in = r.a;
        op_data_in = r.d;
        byte_mode_in = r.bm;
        @(negedge core_clk_in);
        op_valid_in = 1'b0;
        for (k = 0; done !== 1'b1 && k < 2000; k++) @(negedge core_clk_in);
        if (k >= 2000) begin
            err_total++;
            close_out();
        end
        expect_seq(r);
        check_val("write_count", 19'(n_ex), 19'(flash_lo.log_n - base));
        for (int j = 0; j < n_ex; j++) begin
            m = ex_f[j] ? 16'hffff : 16'h00ff;
            if (ex_c[j]) check_val("write_addr", ex_a[j], flash_lo.log_a[(base + j) % 64]);
            check_val("write_data", 19'(ex_d[j] & m), 19'(flash_lo.log_d[(base + j) % 64] & m));
        end
    endtask : do_op

    task automatic wait_busy(input logic lvl, input int lim);
        for (k = 0; busy !== lvl && k < lim; k++) @(negedge core_clk_in);
        check_val("busy_out", 19'(lvl), 19'(busy));
    endtask : wait_busy

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        err_total = 0;
        n_checks = 0;
        rows = '{'{3'h5, 19'h12345, 16'habcd, 1'b1}, '{3'h5, 19'h7fffe, 16'h5a3c, 1'b0},
                 '{3'h6, 19'h00000, 16'h0000, 1'b0}, '{3'h7, 19'h00000, 16'h0000, 1'b0},
                 '{3'h1, 19'h3f5a7, 16'h0000, 1'b1}, '{3'h2, 19'h7ffff, 16'h0000, 1'b1},
                 '{3'h3, 19'h00000, 16'h0000, 1'b1}, '{3'h4, 19'h00000, 16'h0000, 1'b0}};
        repeat (3) @(negedge core_clk_in);
        check_val("reset_pins", 19'h0000f, 19'({rdy, oe, we_n, cs_n, frst_n, oe_n}));
        repeat (2) @(negedge core_clk_in);
        rst_in = 1'b0;
        for (int i = 0; i < 8; i++) begin
            do_op(rows[i]);
            check_val("width_select", 19'(!rows[i].bm), 19'(wsel));
            if (rows[i].op == fec_pkg::OP_SUSPEND) begin
                @(negedge core_clk_in);
                check_val("suspend_wait", 19'h00001, 19'(swait));
            end
        end
        wait_busy(1'b1, 10);
        wait_busy(1'b0, 1000);
        check_val("suspend_wait", 19'h00000, 19'(swait));
        do_op('{3'h0, 19'h00000, 16'h0000, 1'b0});
        wait_busy(1'b1, 10);
        hw_reset_in = 1'b1;
        @(negedge core_clk_in);
        hw_reset_in = 1'b0;
        for (k = 0; frst_n !== 1'b0 && k < 20; k++) @(negedge core_clk_in);
        for (k = 0; frst_n === 1'b0 && k < 1000; k++) @(negedge core_clk_in);
        check_val("reset_pulse", 19'h00001, 19'(k >= fec_pkg::RESET_PULSE_CYC && k < 1000));
        wait_busy(1'b0, 10);
        close_out();
    end
endmodule : tb
